/* File: core/wdsup_top.sv */
// Watchdog supervisor: locked control register, timeout counter, reset and interrupt actions
//
// Contract
// RULE_01 - The timeout lasts two to the prescale code times 512 periods of a 32.768 kHz crystal.
// RULE_02 - Prescale code 8 resets at once; codes above 8 are reserved and must not be chosen.
// RULE_03 - The watchdog interrupt ignores the global interrupt enable and has fixed high priority.
// RULE_04 - Every watchdog timeout sets the timeout flag.
// RULE_05 - The timeout flag clears by a written zero or hardware reset, never by a watchdog reset.
// RULE_06 - Setting the enable bit starts the watchdog and clears its count; missing refresh fires.
// RULE_07 - Enable clears on written zero, on reset action, on hardware reset and on supply alarm.
// RULE_08 - A control write counts only right after the access that set the unlock bit.
// RULE_09 - Software keeps interrupts off across the unlock-and-write pair.
// RULE_10 - In interrupt mode the watchdog acts as a periodic timer raising its interrupt each period.
// RULE_11 - Select bit 0 makes a timeout reset the device, 1 raises the watchdog interrupt.
`include "wdsup_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wdsup_top
	import wdsup_pkg::*;
#(
	parameter int CLK_HZ = `WDSUP_CLK_HZ,
	parameter int XTAL_HZ = `WDSUP_XTAL_HZ,
	parameter int BASE_TICKS = `WDSUP_BASE_TICKS
)
(
	input wire logic mclk, // System clock, 100 MHz
	input wire logic sys_rst, // Hardware reset, synchronous, active high
	input wire logic [3:0] reg_addr, // Register byte address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic supply_monitor, // Supply alarm pulse
	input wire logic wdt_irq_ack, // Core took the watchdog interrupt
	output logic wdt_reset, // Device reset request pulse
	output logic wdt_irq, // Watchdog interrupt, unmaskable
	output logic irq // Event interrupt, level
);
	localparam int CNT_W = 17;

	wdsup_lock_e lock_state;
	wdsup_pre_t timeout_prescale;
	logic irq_or_reset_select;
	logic timeout_flag;
	logic watchdog_on;
	logic [`WDSUP_EV_W-1:0] ev_status;
	logic [`WDSUP_EV_W-1:0] ev_enable;
	logic [`WDSUP_EV_W-1:0] ev_set;
	logic [7:0] next_rdata;
	logic ctrl_wr;
	logic ctrl_accept;
	logic ctrl_refused;
	logic strobe;
	logic tick;
	logic expire;
	logic immediate;
	logic fire;
	logic fire_reset;
	logic fire_irq;
	logic cnt_clear;
	logic cnt_run;

	initial
	begin
		if (BASE_TICKS < 1 || (longint'(BASE_TICKS) << 7) > (longint'(1) << CNT_W))
			$error("wdsup_top: BASE_TICKS out of range");
	end

	assign strobe = reg_wr || reg_rd;
	assign ctrl_wr = reg_wr && reg_addr == `WDSUP_OFS_CTRL;

	// RULE_08 - accept only after unlock
	assign ctrl_accept = ctrl_wr && lock_state == WDSUP_ARMED;
	assign ctrl_refused = ctrl_wr && lock_state == WDSUP_LOCKED
		&& !reg_wdata[`WDSUP_CTRL_UNLOCK];

	// RULE_08 - unlock lasts one access
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			lock_state <= WDSUP_LOCKED;
		else if (strobe)
		begin
			case (lock_state)
				WDSUP_LOCKED:
					if (ctrl_wr && reg_wdata[`WDSUP_CTRL_UNLOCK])
						lock_state <= WDSUP_ARMED;
				WDSUP_ARMED:
					lock_state <= WDSUP_LOCKED;
				default:
					lock_state <= WDSUP_LOCKED;
			endcase
		end
	end

	wdsup_xtal_tick #(
		.CLK_HZ(CLK_HZ),
		.XTAL_HZ(XTAL_HZ)
	) u_tick (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	// RULE_06 - enable write restarts count
	assign cnt_clear = ctrl_accept || fire;
	// RULE_02 - reserved codes never count
	assign cnt_run = watchdog_on && timeout_prescale <= `WDSUP_PRE_MAX;

	wdsup_period_cnt #(
		.BASE_TICKS(BASE_TICKS),
		.CNT_W(CNT_W)
	) u_cnt (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clear(cnt_clear),
		.run(cnt_run),
		.tick(tick),
		.pre(timeout_prescale),
		.expire(expire)
	);

	// RULE_02 - code 8 fires at once
	assign immediate = watchdog_on && timeout_prescale == `WDSUP_PRE_IMMEDIATE;
	assign fire = (expire && cnt_run) || immediate;
	// RULE_11 - select picks the action, except code 8 always resets
	assign fire_reset = fire && (!irq_or_reset_select || immediate);
	assign fire_irq = fire && irq_or_reset_select && !immediate;

	// Prescale and select fields
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			timeout_prescale <= `WDSUP_PRE_RST;
			irq_or_reset_select <= 1'b0;
		end
		else if (ctrl_accept)
		begin
			timeout_prescale <= reg_wdata[`WDSUP_CTRL_PRE_HI:`WDSUP_CTRL_PRE_LO];
			irq_or_reset_select <= reg_wdata[`WDSUP_CTRL_SEL];
		end
	end

	// RULE_07 - enable clearing sources
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			watchdog_on <= 1'b0;
		else if (fire_reset || supply_monitor)
			watchdog_on <= 1'b0;
		else if (ctrl_accept)
			watchdog_on <= reg_wdata[`WDSUP_CTRL_ON];
	end

	// RULE_04 - timeout sets flag
	// RULE_05 - only written zero or hardware reset clear it
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			timeout_flag <= 1'b0;
		else if (fire)
			timeout_flag <= 1'b1;
		else if (ctrl_accept && !reg_wdata[`WDSUP_CTRL_FLAG])
			timeout_flag <= 1'b0;
	end

	// Reset request pulse
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			wdt_reset <= 1'b0;
		else
			wdt_reset <= fire_reset;
	end

	// RULE_03 - no mask, no global enable
	// RULE_10 - raised at every period
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			wdt_irq <= 1'b0;
		else if (fire_irq)
			wdt_irq <= 1'b1;
		else if (wdt_irq_ack)
			wdt_irq <= 1'b0;
	end

	// Sticky events, set wins over clear
	always_comb
	begin
		ev_set = '0;
		ev_set[`WDSUP_EV_EXPIRE] = fire;
		ev_set[`WDSUP_EV_REFUSED] = ctrl_refused;
		ev_set[`WDSUP_EV_SUPPLY] = supply_monitor && watchdog_on;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ev_status <= `WDSUP_EV_RST;
		else if (reg_wr && reg_addr == `WDSUP_OFS_CLEAR)
			ev_status <= (ev_status & ~reg_wdata[`WDSUP_EV_W-1:0]) | ev_set;
		else
			ev_status <= ev_status | ev_set;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ev_enable <= `WDSUP_EV_RST;
		else if (reg_wr && reg_addr == `WDSUP_OFS_IEN)
			ev_enable <= reg_wdata[`WDSUP_EV_W-1:0];
	end

	assign irq = |(ev_status & ev_enable);

	// Read mux
	always_comb
	begin
		next_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`WDSUP_OFS_CTRL:
				begin
					next_rdata[`WDSUP_CTRL_PRE_HI:`WDSUP_CTRL_PRE_LO] = timeout_prescale;
					next_rdata[`WDSUP_CTRL_SEL] = irq_or_reset_select;
					next_rdata[`WDSUP_CTRL_FLAG] = timeout_flag;
					next_rdata[`WDSUP_CTRL_ON] = watchdog_on;
					next_rdata[`WDSUP_CTRL_UNLOCK] = lock_state == WDSUP_ARMED;
				end
				`WDSUP_OFS_STATUS:
					next_rdata[`WDSUP_EV_W-1:0] = ev_status;
				`WDSUP_OFS_IEN:
					next_rdata[`WDSUP_EV_W-1:0] = ev_enable;
				default:
					next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end
endmodule
`default_nettype wire

/* File: core/wdsup_consts.svh */
// Offsets, field positions, reset values and timing figures of the watchdog supervisor
`ifndef WDSUP_CONSTS_SVH
`define WDSUP_CONSTS_SVH

// Register byte addresses
`define WDSUP_OFS_CTRL 4'h0
`define WDSUP_OFS_STATUS 4'h4
`define WDSUP_OFS_CLEAR 4'h8
`define WDSUP_OFS_IEN 4'hc

// Control register fields
`define WDSUP_CTRL_PRE_HI 7
`define WDSUP_CTRL_PRE_LO 4
`define WDSUP_CTRL_SEL 3
`define WDSUP_CTRL_FLAG 2
`define WDSUP_CTRL_ON 1
`define WDSUP_CTRL_UNLOCK 0

// Event bits of status, clear and enable
`define WDSUP_EV_EXPIRE 0
`define WDSUP_EV_REFUSED 1
`define WDSUP_EV_SUPPLY 2
`define WDSUP_EV_W 3

// Reset values
`define WDSUP_PRE_RST 4'h0
`define WDSUP_EV_RST 3'h0

// Timing
`define WDSUP_CLK_HZ 100000000
`define WDSUP_XTAL_HZ 32768
`define WDSUP_BASE_TICKS 512
`define WDSUP_PRE_MAX 4'h7
`define WDSUP_PRE_IMMEDIATE 4'h8

`endif

/* File: core/wdsup_pkg.sv */
// Types shared by the watchdog supervisor modules
package wdsup_pkg;
	typedef enum logic {
		WDSUP_LOCKED,
		WDSUP_ARMED
	} wdsup_lock_e;
	typedef logic [3:0] wdsup_pre_t;
endpackage

/* File: core/wdsup_xtal_tick.sv */
// Fractional divider giving one enable pulse per crystal period
`timescale 1ns/1ps
`default_nettype none
module wdsup_xtal_tick
	import wdsup_pkg::*;
#(
	parameter int CLK_HZ = 100000000,
	parameter int XTAL_HZ = 32768
)
(
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	output logic tick // One cycle per crystal period
);
	logic [31:0] acc;
	logic [32:0] sum;

	initial
	begin
		if (XTAL_HZ < 1 || XTAL_HZ > CLK_HZ)
			$error("wdsup_xtal_tick: crystal rate must lie in 1..CLK_HZ");
	end

	assign sum = {1'b0, acc} + 33'(XTAL_HZ);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			acc <= 32'h0;
			tick <= 1'b0;
		end
		else if (sum >= 33'(CLK_HZ))
		begin
			acc <= 32'(sum - 33'(CLK_HZ));
			tick <= 1'b1;
		end
		else
		begin
			acc <= sum[31:0];
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: core/wdsup_period_cnt.sv */
// Prescaled timeout counter in crystal ticks
`timescale 1ns/1ps
`default_nettype none
module wdsup_period_cnt
	import wdsup_pkg::*;
#(
	parameter int BASE_TICKS = 512,
	parameter int CNT_W = 17
)
(
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic clear, // Restart the period
	input wire logic run, // Count enable
	input wire logic tick, // Crystal period pulse
	input wire wdsup_pre_t pre, // Prescale code 0..7
	output logic expire // Pulse at end of period
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] last;

	initial
	begin
		if ((longint'(BASE_TICKS) << 7) > (longint'(1) << CNT_W))
			$error("wdsup_period_cnt: CNT_W too small for longest period");
	end

	assign last = CNT_W'((longint'(BASE_TICKS) << pre[2:0]) - 1);

	// RULE_01 - period 2^pre x 512
	always_ff @(posedge mclk)
	begin
		if (sys_rst || clear || !run)
		begin
			count <= '0;
			expire <= 1'b0;
		end
		else if (tick && count >= last)
		begin
			count <= '0;
			expire <= 1'b1;
		end
		else
		begin
			if (tick)
				count <= count + CNT_W'(1);
			expire <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: dv/wdsup_top_checker.sv */
// Port-level assertion checker for the watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module wdsup_top_checker
(
	input wire logic mclk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [3:0] reg_addr, // Address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic supply_monitor, // Supply alarm
	input wire logic wdt_irq_ack, // Interrupt ack
	input wire logic wdt_reset, // Reset request
	input wire logic wdt_irq, // Watchdog interrupt
	input wire logic irq // Event interrupt
);
	logic armed;
	logic acc;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Unlock is consumed by the next strobe
	always_ff @(posedge mclk)
		if (sys_rst)
			armed <= 1'h0;
		else if (reg_wr || reg_rd)
			armed <= reg_wr && reg_addr == 4'h0 && reg_wdata[0] && !armed;
	assign acc = armed && reg_wr && reg_addr == 4'h0;
	a_reset_pulse_once: assert property (wdt_reset |=> !wdt_reset [*2])
		else $error("watchdog reset repeated");
	a_irq_held_level: assert property (wdt_irq && !wdt_irq_ack |=> wdt_irq)
		else $error("watchdog interrupt dropped");
	a_ack_clears_irq: assert property (wdt_irq && wdt_irq_ack |=> !wdt_irq)
		else $error("watchdog interrupt not serviced");
	a_single_action: assert property ($rose(wdt_irq) |-> !wdt_reset)
		else $error("both timeout actions at once");
	a_immediate_reset: assert property (acc && reg_wdata[7:4] == 4'h8 && reg_wdata[1]
		|-> ##[1:3] wdt_reset)
		else $error("prescale eight did not reset");
	a_shortest_period: assert property (acc && reg_wdata[7:4] == 4'h0 && reg_wdata[1]
		|-> ##[1:8] (wdt_reset || wdt_irq))
		else $error("shortest timeout missed");
	a_supply_stops: assert property (supply_monitor && !reg_wr
		|-> ##2 (!wdt_reset && !$rose(wdt_irq)) [*6])
		else $error("timeout after supply alarm");
	a_locked_write: assert property (reg_wr && reg_addr == 4'h0 && !armed && !reg_wdata[0]
		|=> !wdt_reset [*4])
		else $error("locked control write took effect");
	c_enable: cover property (acc && reg_wdata[1]);
	c_irq: cover property ($rose(wdt_irq));
	c_reset: cover property (wdt_reset);
endmodule
bind wdsup_top wdsup_top_checker wdsup_top_checker_i (.mclk, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .supply_monitor, .wdt_irq_ack, .wdt_reset, .wdt_irq, .irq);
`default_nettype wire

/* File: dv/tb_wdsup_top.sv */
// Self-checking bench for the watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h", $time, a); end end
module tb_wdsup_top;
	logic mclk = 1'h0;
	logic sys_rst = 1'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic supply_monitor = 1'h0;
	logic wdt_irq_ack = 1'h0;
	logic [7:0] reg_rdata;
	logic wdt_reset;
	logic wdt_irq;
	logic irq;
	logic saw_rst = 1'h0;
	int fails = 0;
	int num_checks = 0;
	int cyc;
	always #5 mclk = ~mclk;
	always @(posedge mclk)
		if (wdt_reset === 1'h1)
			saw_rst <= 1'h1;
	// Crystal tick every 4 cycles, one tick per prescale unit
	wdsup_top #(.XTAL_HZ(25000000), .BASE_TICKS(1)) wdsup_top_i (.mclk, .sys_rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_monitor, .wdt_irq_ack, .wdt_reset,
		.wdt_irq, .irq);
	task wrap_up;
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		#1;
	endtask
	// unlock then write, no strobe between
	task ctl(input logic [7:0] d);
		wr(4'h0, 8'h01);
		wr(4'h0, d);
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	task ack;
		@(posedge mclk);
		wdt_irq_ack <= 1'h1;
		@(posedge mclk);
		wdt_irq_ack <= 1'h0;
	endtask
	task await(input logic want_irq, input int lim);
		for (cyc = 0; cyc < lim; cyc++)
		begin
			@(posedge mclk);
			#1;
			if ((want_irq ? wdt_irq : wdt_reset) === 1'h1)
				break;
		end
		if (cyc == lim)
		begin
			fails++;
			wrap_up();
		end
	endtask
	task t_locked;
		wr(4'h0, 8'h82);
		rc(4'h0, 8'h00);
		wr(4'h0, 8'h01);
		rc(4'h4, 8'h02);
		wr(4'h0, 8'h72);
		rc(4'h0, 8'h00);
		wr(4'hc, 8'h02);
		`CHK(irq, 1'h1)
		wr(4'hc, 8'h00);
		`CHK(irq, 1'h0)
		wr(4'hc, 8'h02);
		wr(4'h8, 8'h02);
		`CHK(irq, 1'h0)
		rc(4'h2, 8'h00);
		wr(4'hc, 8'h00);
	endtask
	task t_periodic;
		for (int p = 0; p < 4; p++)
		begin
			ctl({p[3:0], 4'ha});
			ack();
			await(1'h1, 200);
			ack();
			await(1'h1, 200);
			`CHK(cyc, (4 << p) - 3)
			`CHK(irq, 1'h0)
		end
		rc(4'h0, 8'h3e);
		rc(4'h4, 8'h01);
		ctl(8'h00);
		ack();
	endtask
	task t_reset_action;
		ctl(8'h02);
		await(1'h0, 50);
		rc(4'h0, 8'h04);
		saw_rst <= 1'h0;
		repeat (6) ctl(8'h16);
		ctl(8'h10);
		repeat (40) @(posedge mclk);
		`CHK(saw_rst, 1'h0)
		rc(4'h0, 8'h10);
	endtask
	task t_immediate;
		ctl(8'h82);
		await(1'h0, 4);
		rc(4'h0, 8'h84);
		@(posedge mclk);
		sys_rst <= 1'h1;
		@(posedge mclk);
		sys_rst <= 1'h0;
		rc(4'h0, 8'h00);
	endtask
	task t_supply;
		wr(4'h8, 8'h07);
		ctl(8'h72);
		@(posedge mclk);
		supply_monitor <= 1'h1;
		@(posedge mclk);
		supply_monitor <= 1'h0;
		rc(4'h0, 8'h70);
		rc(4'h4, 8'h04);
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'h0;
		rc(4'h0, 8'h00);
		t_locked();
		t_periodic();
		t_reset_action();
		t_immediate();
		t_supply();
		wrap_up();
	end
endmodule
`default_nettype wire
